// >>> hdl/hcpfe_top.sv
// Host command port front end: serial and USB byte inputs, source select,
// echo, parameter collection and completion byte.
// Assumes the USB side is a byte stream from a bridge on the same clock.
// Overview of operation
// - Every command is one raw eight-bit byte.
// - Parameter-bearing commands gather their trailing bytes before execution starts.
// - Each byte accepted while idle or awaiting a parameter is echoed immediately.
// - After the operation completes, a carriage return byte is sent.
// - Reset selects the serial port as command source.
// - Online key reselects the serial port.
// - A valid serial command makes serial the active source.
// - A source change refreshes the display bottom line indication.
// - Serial stays active until a valid USB command selects USB or the local key selects keypad.
// - Local key drops remote control and selects keypad control.
// - Decode, parameters, echo, completion are the same for both ports.
// - Serial link runs 9600 baud, 8 data, no parity, 1 stop.
// - Movement byte: wheel bit 7, speed bits 6:4, position low nibble up to 9.
`timescale 1ns/1ps
module hcpfe_top #(
  parameter int BIT_CYCLES = hcpfe_pkg::BIT_CYCLES
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ser_rx,
  output logic            o_ser_tx,
  input  wire logic       i_usb_rx_valid,
  input  wire logic [7:0] i_usb_rx_data,
  output logic            o_usb_tx_valid,
  output logic [7:0]      o_usb_tx_data,
  input  wire logic       i_usb_tx_ready,
  input  wire logic       i_key_online,
  input  wire logic       i_key_local,
  output logic            o_cmd_valid,
  output logic [7:0]      o_cmd_code,
  output logic [7:0]      o_cmd_param,
  output logic            o_cmd_is_move,
  output logic [3:0]      o_move_pos,
  output logic [2:0]      o_move_speed,
  input  wire logic       i_op_done,
  output logic [1:0]      o_src,
  output logic            o_disp_update
);
  // ********************************************************************
  // Serial physical layer
  // ********************************************************************
  logic       ser_rx_valid;
  logic [7:0] ser_rx_data;
  logic       ser_tx_ready;
  logic       ser_tx_valid;
  logic [7:0] ser_tx_data;
  logic       next_ser_tx_valid;
  logic [7:0] next_ser_tx_data;

  hcpfe_uart_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_rx      (i_ser_rx),
    .o_valid   (ser_rx_valid),
    .o_data    (ser_rx_data)
  );
  hcpfe_uart_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_valid   (ser_tx_valid),
    .i_data    (ser_tx_data),
    .o_ready   (ser_tx_ready),
    .o_tx      (o_ser_tx)
  );

  // ********************************************************************
  // Key synchronisers
  // ********************************************************************
  logic key_on1;
  logic key_on2;
  logic key_lo1;
  logic key_lo2;

  // ********************************************************************
  // Response buffer: two entries, carries echo and CR bytes
  // ********************************************************************
  hcpfe_pkg::hcpfe_byte_s buf_mem [2];
  hcpfe_pkg::hcpfe_byte_s next_buf_mem [2];
  logic                   buf_rd;
  logic                   next_buf_rd;
  logic [1:0]             buf_cnt;
  logic [1:0]             next_buf_cnt;
  logic                   push;
  hcpfe_pkg::hcpfe_byte_s push_byte;
  logic                   pop;
  logic                   out_ready;
  logic                   buf_full;

  assign buf_full = (buf_cnt == 2'h2);

  // ********************************************************************
  // Command state
  // ********************************************************************
  typedef enum logic [1:0] {
    HCPFE_ST_IDLE  = 2'b00,
    HCPFE_ST_PARAM = 2'b01,
    HCPFE_ST_EXEC  = 2'b10,
    HCPFE_ST_CR    = 2'b11
  } hcpfe_st_e;

  hcpfe_st_e  st;
  hcpfe_st_e  next_st;
  logic [1:0] prm_left;
  logic [1:0] next_prm_left;
  logic       cur_usb;
  logic       next_cur_usb;
  logic [1:0] next_src;
  logic       next_disp_update;
  logic       next_cmd_valid;
  logic [7:0] next_cmd_code;
  logic [7:0] next_cmd_param;
  logic       next_cmd_is_move;
  logic [3:0] next_move_pos;
  logic [2:0] next_move_speed;

  function automatic logic is_move(input logic [7:0] b);
    hcpfe_pkg::hcpfe_move_s m;
    m = b;
    return (m.pos <= hcpfe_pkg::POS_MAX);
  endfunction

  function automatic logic needs_param(input logic [7:0] b);
    return (!is_move(b) && b == hcpfe_pkg::PARAM_CMD);
  endfunction

  // Only one byte taken per cycle; serial wins a same-cycle collision
  logic       in_valid;
  logic       in_usb;
  logic [7:0] in_byte;
  logic       remote;

  always_comb begin
    in_valid = ser_rx_valid | i_usb_rx_valid;
    in_usb   = !ser_rx_valid;
    in_byte  = ser_rx_valid ? ser_rx_data : i_usb_rx_data;
  end

  assign remote = (o_src != 2'(hcpfe_pkg::HCPFE_SRC_LOCAL));

  always_comb begin
    next_st          = st;
    next_prm_left    = prm_left;
    next_cur_usb     = cur_usb;
    next_src         = o_src;
    next_cmd_valid   = 1'b0;
    next_cmd_code    = o_cmd_code;
    next_cmd_param   = o_cmd_param;
    next_cmd_is_move = o_cmd_is_move;
    next_move_pos    = o_move_pos;
    next_move_speed  = o_move_speed;
    push             = 1'b0;
    push_byte        = '{from_usb: 1'b0, data: 8'h00};
    // Bytes during execution or with a full buffer are dropped; the host
    // must wait for CR, since the link has no flow control.
    case (st)
      HCPFE_ST_IDLE: begin
        if (in_valid && remote && !buf_full) begin
          push      = 1'b1;
          push_byte = '{from_usb: in_usb, data: in_byte};
          next_cur_usb  = in_usb;
          next_cmd_code = in_byte;
          next_cmd_is_move = is_move(in_byte);
          next_move_pos    = in_byte[hcpfe_pkg::POS_W-1:0];
          next_move_speed  = in_byte[hcpfe_pkg::SPEED_LSB +: hcpfe_pkg::SPEED_W];
          next_src = in_usb ? 2'(hcpfe_pkg::HCPFE_SRC_USB)
                            : 2'(hcpfe_pkg::HCPFE_SRC_SERIAL);
          if (needs_param(in_byte)) begin
            next_st       = HCPFE_ST_PARAM;
            next_prm_left = hcpfe_pkg::PARAM_CNT;
          end else begin
            next_st        = HCPFE_ST_EXEC;
            next_cmd_valid = 1'b1;
          end
        end
      end
      HCPFE_ST_PARAM: begin
        if (in_valid && remote && in_usb == cur_usb && !buf_full) begin
          push           = 1'b1;
          push_byte      = '{from_usb: in_usb, data: in_byte};
          next_cmd_param = in_byte;
          next_prm_left  = prm_left - 2'h1;
          if (prm_left == 2'h1) begin
            next_st        = HCPFE_ST_EXEC;
            next_cmd_valid = 1'b1;
          end
        end
      end
      HCPFE_ST_EXEC: begin
        if (i_op_done) next_st = HCPFE_ST_CR;
      end
      HCPFE_ST_CR: begin
        if (!buf_full) begin
          push      = 1'b1;
          push_byte = '{from_usb: cur_usb, data: hcpfe_pkg::CR_BYTE};
          next_st   = HCPFE_ST_IDLE;
        end
      end
      default: next_st = HCPFE_ST_IDLE;
    endcase
    // Keys override; local abandons any partial command
    if (key_on2) begin
      next_src = 2'(hcpfe_pkg::HCPFE_SRC_SERIAL);
    end else if (key_lo2) begin
      next_src = 2'(hcpfe_pkg::HCPFE_SRC_LOCAL);
      if (next_st == HCPFE_ST_PARAM) next_st = HCPFE_ST_IDLE;
    end
  end

  assign next_disp_update = (next_src != o_src);

  // ********************************************************************
  // Buffer next state and output routing
  // ********************************************************************
  hcpfe_pkg::hcpfe_byte_s head;
  assign head      = buf_mem[buf_rd];
  assign out_ready = head.from_usb ? (!o_usb_tx_valid || i_usb_tx_ready)
                                   : (ser_tx_ready && !ser_tx_valid);
  assign pop       = (buf_cnt != 2'h0) && out_ready;

  always_comb begin
    next_buf_mem = buf_mem;
    next_buf_rd  = buf_rd;
    next_buf_cnt = buf_cnt;
    if (pop) begin
      next_buf_rd  = !buf_rd;
      next_buf_cnt = next_buf_cnt - 2'h1;
    end
    if (push) begin
      next_buf_mem[buf_rd ^ buf_cnt[0]] = push_byte;
      next_buf_cnt = next_buf_cnt + 2'h1;
    end
    next_ser_tx_valid = pop && !head.from_usb;
    next_ser_tx_data  = pop && !head.from_usb ? head.data : ser_tx_data;
  end

  logic       next_usb_tx_valid;
  logic [7:0] next_usb_tx_data;
  always_comb begin
    next_usb_tx_valid = o_usb_tx_valid && !i_usb_tx_ready;
    next_usb_tx_data  = o_usb_tx_data;
    if (pop && head.from_usb) begin
      next_usb_tx_valid = 1'b1;
      next_usb_tx_data  = head.data;
    end
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      key_on1        <= 1'b0;
      key_on2        <= 1'b0;
      key_lo1        <= 1'b0;
      key_lo2        <= 1'b0;
      st             <= HCPFE_ST_IDLE;
      prm_left       <= 2'h0;
      cur_usb        <= 1'b0;
      o_src          <= 2'(hcpfe_pkg::HCPFE_SRC_SERIAL);
      o_disp_update  <= 1'b0;
      o_cmd_valid    <= 1'b0;
      o_cmd_code     <= 8'h00;
      o_cmd_param    <= 8'h00;
      o_cmd_is_move  <= 1'b0;
      o_move_pos     <= 4'h0;
      o_move_speed   <= 3'h0;
      buf_mem[0]     <= '{from_usb: 1'b0, data: 8'h00};
      buf_mem[1]     <= '{from_usb: 1'b0, data: 8'h00};
      buf_rd         <= 1'b0;
      buf_cnt        <= 2'h0;
      ser_tx_valid   <= 1'b0;
      ser_tx_data    <= 8'h00;
      o_usb_tx_valid <= 1'b0;
      o_usb_tx_data  <= 8'h00;
    end else begin
      key_on1        <= i_key_online;
      key_on2        <= key_on1;
      key_lo1        <= i_key_local;
      key_lo2        <= key_lo1;
      st             <= next_st;
      prm_left       <= next_prm_left;
      cur_usb        <= next_cur_usb;
      o_src          <= next_src;
      o_disp_update  <= next_disp_update;
      o_cmd_valid    <= next_cmd_valid;
      o_cmd_code     <= next_cmd_code;
      o_cmd_param    <= next_cmd_param;
      o_cmd_is_move  <= next_cmd_is_move;
      o_move_pos     <= next_move_pos;
      o_move_speed   <= next_move_speed;
      buf_mem        <= next_buf_mem;
      buf_rd         <= next_buf_rd;
      buf_cnt        <= next_buf_cnt;
      ser_tx_valid   <= next_ser_tx_valid;
      ser_tx_data    <= next_ser_tx_data;
      o_usb_tx_valid <= next_usb_tx_valid;
      o_usb_tx_data  <= next_usb_tx_data;
    end
  end
endmodule

// >>> hdl/hcpfe_uart_rx.sv
// Serial receiver, 8N1, for the command port.
// Assumes i_rx comes straight from the pin; it is synchronised here.
`timescale 1ns/1ps
module hcpfe_uart_rx #(
  parameter int BIT_CYCLES = hcpfe_pkg::BIT_CYCLES
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_rx,
  output logic            o_valid,
  output logic [7:0]      o_data
);
  initial begin
    if (BIT_CYCLES < 4) $error("BIT_CYCLES too small");
  end
  localparam int CW = $clog2(BIT_CYCLES + 1);
  logic          sync1;
  logic          sync2;
  logic          busy;
  logic          next_busy;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic [3:0]    bitn;
  logic [3:0]    next_bitn;
  logic [7:0]    shreg;
  logic [7:0]    next_shreg;
  logic          next_valid;
  logic [7:0]    next_data;

  always_comb begin
    next_busy  = busy;
    next_cnt   = cnt;
    next_bitn  = bitn;
    next_shreg = shreg;
    next_valid = 1'b0;
    next_data  = o_data;
    if (!busy) begin
      if (!sync2) begin
        next_busy = 1'b1;
        // Half bit first so every sample lands mid-bit
        next_cnt  = CW'(BIT_CYCLES / 2);
        next_bitn = 4'h0;
      end
    end else if (cnt == '0) begin
      next_cnt = CW'(BIT_CYCLES - 1);
      if (bitn == 4'h0) begin
        if (sync2) next_busy = 1'b0;
        next_bitn = 4'h1;
      end else if (bitn <= 4'(hcpfe_pkg::DATA_BITS)) begin
        next_shreg = {sync2, shreg[7:1]};
        next_bitn  = bitn + 4'h1;
      end else begin
        next_busy = 1'b0;
        // Framing error drops the byte silently
        if (sync2) begin
          next_valid = 1'b1;
          next_data  = shreg;
        end
      end
    end else begin
      next_cnt = cnt - CW'(1);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1   <= 1'b1;
      sync2   <= 1'b1;
      busy    <= 1'b0;
      cnt     <= '0;
      bitn    <= 4'h0;
      shreg   <= 8'h00;
      o_valid <= 1'b0;
      o_data  <= 8'h00;
    end else begin
      sync1   <= i_rx;
      sync2   <= sync1;
      busy    <= next_busy;
      cnt     <= next_cnt;
      bitn    <= next_bitn;
      shreg   <= next_shreg;
      o_valid <= next_valid;
      o_data  <= next_data;
    end
  end
endmodule

// >>> hdl/hcpfe_uart_tx.sv
// Serial transmitter, 8N1, with a valid/ready byte input.
// Assumes the caller holds data steady while valid and not ready.
`timescale 1ns/1ps
module hcpfe_uart_tx #(
  parameter int BIT_CYCLES = hcpfe_pkg::BIT_CYCLES
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_valid,
  input  wire logic [7:0] i_data,
  output logic            o_ready,
  output logic            o_tx
);
  initial begin
    if (BIT_CYCLES < 4) $error("BIT_CYCLES too small");
  end
  localparam int CW = $clog2(BIT_CYCLES + 1);
  logic          busy;
  logic          next_busy;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic [3:0]    bitn;
  logic [3:0]    next_bitn;
  logic [9:0]    frame;
  logic [9:0]    next_frame;
  logic          next_tx;

  assign o_ready = !busy;

  always_comb begin
    next_busy  = busy;
    next_cnt   = cnt;
    next_bitn  = bitn;
    next_frame = frame;
    next_tx    = o_tx;
    if (!busy) begin
      next_tx = 1'b1;
      if (i_valid) begin
        next_busy  = 1'b1;
        next_frame = {1'b1, i_data, 1'b0};
        next_cnt   = CW'(BIT_CYCLES - 1);
        next_bitn  = 4'h0;
        next_tx    = 1'b0;
      end
    end else if (cnt == '0) begin
      next_cnt = CW'(BIT_CYCLES - 1);
      if (bitn == 4'(hcpfe_pkg::DATA_BITS + hcpfe_pkg::STOP_BITS)) begin
        next_busy = 1'b0;
        next_tx   = 1'b1;
      end else begin
        next_bitn = bitn + 4'h1;
        next_tx   = frame[bitn + 4'h1];
      end
    end else begin
      next_cnt = cnt - CW'(1);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      busy  <= 1'b0;
      cnt   <= '0;
      bitn  <= 4'h0;
      frame <= 10'h3ff;
      o_tx  <= 1'b1;
    end else begin
      busy  <= next_busy;
      cnt   <= next_cnt;
      bitn  <= next_bitn;
      frame <= next_frame;
      o_tx  <= next_tx;
    end
  end
endmodule

// >>> pkg/hcpfe_pkg.sv
// Constants and carrier types for the host command port front end.
// Assumes one 100 MHz system clock shared by every user.
package hcpfe_pkg;
  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_HZ        = 100000000;
  localparam int BAUD          = 9600;
  localparam int BIT_CYCLES    = CLK_HZ / BAUD;
  localparam int DATA_BITS     = 8;
  localparam int STOP_BITS     = 1;
  // ********************************************************************
  // Command byte layout
  // ********************************************************************
  localparam int  WHEEL_BIT    = 7;
  localparam int  SPEED_LSB    = 4;
  localparam int  SPEED_W      = 3;
  localparam int  POS_W        = 4;
  localparam logic [3:0] POS_MAX   = 4'h9;
  localparam logic [7:0] CR_BYTE   = 8'h0d;
  // Special command code that carries one trailing parameter byte
  localparam logic [7:0] PARAM_CMD = 8'hfa;
  localparam logic [1:0] PARAM_CNT = 2'h1;
  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [1:0] {
    HCPFE_SRC_SERIAL = 2'b00,
    HCPFE_SRC_USB    = 2'b01,
    HCPFE_SRC_LOCAL  = 2'b10
  } hcpfe_src_e;

  typedef struct packed {
    logic                 wheel;
    logic [SPEED_W-1:0]   speed;
    logic [POS_W-1:0]     pos;
  } hcpfe_move_s;

  typedef struct packed {
    logic       from_usb;
    logic [7:0] data;
  } hcpfe_byte_s;
endpackage

// >>> verif/hcpfe_host_model.sv
// Host computer model: serial and USB byte source, echo and completion sink.
// Assumes the front end's single clock; bytes seen are queued for the bench.
`timescale 1ns/1ps
module hcpfe_host_model #(
  parameter int BIT_CYCLES = 16
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_slow,
  input  wire logic       i_ser_tx,
  output logic            o_ser_rx,
  output logic            o_usb_valid,
  output logic [7:0]      o_usb_data,
  input  wire logic       i_usb_valid,
  input  wire logic [7:0] i_usb_data,
  output logic            o_usb_ready
);
  logic [7:0] ser_q[$];
  logic [7:0] usb_q[$];
  logic [7:0] rx_byte;
  logic       nrdy;

  initial begin
    o_ser_rx    = 1'b1;
    o_usb_valid = 1'b0;
    o_usb_data  = 8'h5a;
    o_usb_ready = 1'b1;
  end

  // ****************************************
  // Sending: raw byte values, never digits
  // ****************************************
  task automatic send_ser(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge i_sys_clk);
      o_ser_rx = frame[i];
      repeat (BIT_CYCLES - 1) @(negedge i_sys_clk);
    end
  endtask

  task automatic send_usb(input logic [7:0] b);
    @(negedge i_sys_clk);
    o_usb_valid = 1'b1;
    o_usb_data  = b;
    @(negedge i_sys_clk);
    o_usb_valid = 1'b0;
    o_usb_data  = ~b; // Stale data must not look valid
  endtask

  // ****************************************
  // Receiving
  // ****************************************
  always begin
    @(negedge i_ser_tx);
    repeat (BIT_CYCLES / 2) @(posedge i_sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge i_sys_clk);
      rx_byte[i] = i_ser_tx;
    end
    repeat (BIT_CYCLES) @(posedge i_sys_clk);
    // Framing fault drops the byte, so the bench times out on it
    if (i_ser_tx === 1'b1) ser_q.push_back(rx_byte);
  end

  always @(negedge i_sys_clk) begin
    nrdy = i_slow ? ~o_usb_ready : 1'b1;
    o_usb_ready <= nrdy;
    if (i_usb_valid === 1'b1 && nrdy) usb_q.push_back(i_usb_data);
  end
endmodule

// >>> verif/hcpfe_top_checker.sv
// Port checker for the command port front end.
// Assumes it is bound to every hcpfe_top and sees only its ports.
`timescale 1ns/1ps
module hcpfe_top_checker #(
  parameter int BIT_CYCLES = 16
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_usb_rx_valid,
  input  wire logic       o_usb_tx_valid,
  input  wire logic [7:0] o_usb_tx_data,
  input  wire logic       i_key_online,
  input  wire logic       i_key_local,
  input  wire logic       o_cmd_valid,
  input  wire logic [7:0] o_cmd_code,
  input  wire logic       o_cmd_is_move,
  input  wire logic [3:0] o_move_pos,
  input  wire logic [2:0] o_move_speed,
  input  wire logic       i_op_done,
  input  wire logic [1:0] o_src,
  input  wire logic       o_disp_update
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  // ****************************************
  // Key sequences: 2-FF sync plus register
  // ****************************************
  sequence s_online_held;
    i_key_online [*4];
  endsequence
  sequence s_local_held;
    (i_key_local && !i_key_online) [*4];
  endsequence

  property p_disp_tracks;
    o_disp_update == (o_src != $past(o_src));
  endproperty
  property p_usb_echo;
    $rose(o_cmd_valid) && o_src == hcpfe_pkg::HCPFE_SRC_USB |-> ##[0:8] o_usb_tx_valid;
  endproperty
  property p_cr_after_done;
    i_op_done && o_src == hcpfe_pkg::HCPFE_SRC_USB
      |-> ##[1:12] (o_usb_tx_valid && o_usb_tx_data == hcpfe_pkg::CR_BYTE);
  endproperty
  property p_local_quiet;
    o_src == hcpfe_pkg::HCPFE_SRC_LOCAL && $stable(o_src) |-> !o_cmd_valid;
  endproperty
  property p_local_usb;
    i_usb_rx_valid && o_src == hcpfe_pkg::HCPFE_SRC_LOCAL |=> o_src != hcpfe_pkg::HCPFE_SRC_USB;
  endproperty
  property p_move_fields;
    o_cmd_valid |-> o_move_pos == o_cmd_code[3:0] && o_move_speed == o_cmd_code[6:4]
      && o_cmd_is_move == (o_cmd_code[3:0] <= 4'h9);
  endproperty
  property p_cmd_pulse;
    o_cmd_valid |=> !o_cmd_valid;
  endproperty
  property p_online;
    s_online_held |-> o_src == hcpfe_pkg::HCPFE_SRC_SERIAL;
  endproperty
  property p_local;
    s_local_held |-> o_src == hcpfe_pkg::HCPFE_SRC_LOCAL;
  endproperty

  a_disp_tracks: assert property (p_disp_tracks) else $error("display pulse not tied to source change");
  a_usb_echo: assert property (p_usb_echo) else $error("no USB echo after command");
  a_cr_after_done: assert property (p_cr_after_done) else $error("no completion byte");
  a_local_quiet: assert property (p_local_quiet) else $error("command taken in keypad mode");
  a_local_usb: assert property (p_local_usb) else $error("USB byte taken in keypad mode");
  a_move_fields: assert property (p_move_fields) else $error("movement fields wrong");
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("command valid held");
  a_online: assert property (p_online) else $error("online key did not select serial");
  a_local: assert property (p_local) else $error("local key did not select keypad");
endmodule

bind hcpfe_top hcpfe_top_checker #(.BIT_CYCLES(BIT_CYCLES)) u_hcpfe_top_checker (
  .i_sys_clk      (i_sys_clk),
  .i_rst          (i_rst),
  .i_usb_rx_valid (i_usb_rx_valid),
  .o_usb_tx_valid (o_usb_tx_valid),
  .o_usb_tx_data  (o_usb_tx_data),
  .i_key_online   (i_key_online),
  .i_key_local    (i_key_local),
  .o_cmd_valid    (o_cmd_valid),
  .o_cmd_code     (o_cmd_code),
  .o_cmd_is_move  (o_cmd_is_move),
  .o_move_pos     (o_move_pos),
  .o_move_speed   (o_move_speed),
  .i_op_done      (i_op_done),
  .o_src          (o_src),
  .o_disp_update  (o_disp_update)
);

// >>> verif/tb_top.sv
// Self-checking bench for the command port front end.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/1ps
module tb_top;
  localparam int BC = 16;
  logic       i_sys_clk = 1'b0;
  logic       i_rst, o_ser_tx, i_ser_rx, i_usb_rx_valid, o_usb_tx_valid, i_usb_tx_ready;
  logic [7:0] i_usb_rx_data, o_usb_tx_data, o_cmd_code, o_cmd_param;
  logic       i_key_online, i_key_local, o_cmd_valid, o_cmd_is_move, i_op_done, o_disp_update, slow;
  logic [3:0] o_move_pos;
  logic [2:0] o_move_speed;
  logic [1:0] o_src;
  logic [7:0] cap_code, cap_param, cap_flags;
  int         num_errors, compares, n_cmd, n_disp;

  always #5 i_sys_clk = ~i_sys_clk;

  hcpfe_top #(.BIT_CYCLES(BC)) u_hcpfe_top (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ser_rx(i_ser_rx), .o_ser_tx(o_ser_tx),
    .i_usb_rx_valid(i_usb_rx_valid), .i_usb_rx_data(i_usb_rx_data), .o_usb_tx_valid(o_usb_tx_valid),
    .o_usb_tx_data(o_usb_tx_data), .i_usb_tx_ready(i_usb_tx_ready), .i_key_online(i_key_online),
    .i_key_local(i_key_local), .o_cmd_valid(o_cmd_valid), .o_cmd_code(o_cmd_code),
    .o_cmd_param(o_cmd_param), .o_cmd_is_move(o_cmd_is_move), .o_move_pos(o_move_pos),
    .o_move_speed(o_move_speed), .i_op_done(i_op_done), .o_src(o_src), .o_disp_update(o_disp_update));

  hcpfe_host_model #(.BIT_CYCLES(BC)) u_hcpfe_host_model (
    .i_sys_clk(i_sys_clk), .i_slow(slow), .i_ser_tx(o_ser_tx), .o_ser_rx(i_ser_rx),
    .o_usb_valid(i_usb_rx_valid), .o_usb_data(i_usb_rx_data), .i_usb_valid(o_usb_tx_valid),
    .i_usb_data(o_usb_tx_data), .o_usb_ready(i_usb_tx_ready));

  // ****************************************
  // One-cycle pulses caught at the settled edge
  // ****************************************
  always @(negedge i_sys_clk) begin
    if (o_disp_update === 1'b1) n_disp++;
    if (o_cmd_valid === 1'b1) begin
      n_cmd++;
      cap_code  = o_cmd_code;
      cap_param = o_cmd_param;
      cap_flags = {o_cmd_is_move, o_move_speed, o_move_pos};
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic send(input bit usb, input logic [7:0] b);
    if (usb) u_hcpfe_host_model.send_usb(b);
    else u_hcpfe_host_model.send_ser(b);
  endtask

  task automatic get_reply(input bit usb, input logic [7:0] exp, input string what);
    logic [7:0] b;
    int         n;
    n = 0;
    while ((usb ? u_hcpfe_host_model.usb_q.size() : u_hcpfe_host_model.ser_q.size()) == 0 && n < 3000) begin
      @(negedge i_sys_clk);
      n++;
    end
    if (usb && u_hcpfe_host_model.usb_q.size() > 0) b = u_hcpfe_host_model.usb_q.pop_front();
    if (!usb && u_hcpfe_host_model.ser_q.size() > 0) b = u_hcpfe_host_model.ser_q.pop_front();
    chk(what, exp, b);
  endtask

  task automatic run_cmd(input bit usb, input logic [7:0] code, input bit has_prm, input logic [7:0] prm,
                         input logic [1:0] exp_src);
    int n0;
    int n;
    n0 = n_cmd;
    n = 0;
    send(usb, code);
    if (has_prm) send(usb, prm);
    while (n_cmd == n0 && n < 400) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk("command count", 8'h01, 8'(n_cmd - n0));
    chk("command code", code, cap_code);
    if (has_prm) chk("parameter", prm, cap_param);
    chk("move fields", {code[3:0] <= 4'h9, code[6:4], code[3:0]}, cap_flags);
    chk("source", 8'(exp_src), 8'(o_src));
    @(negedge i_sys_clk);
    i_op_done = 1'b1;
    @(negedge i_sys_clk);
    i_op_done = 1'b0;
    get_reply(usb, code, "echo");
    if (has_prm) get_reply(usb, prm, "parameter echo");
    get_reply(usb, hcpfe_pkg::CR_BYTE, "completion");
  endtask

  task automatic press(input bit online);
    @(negedge i_sys_clk);
    if (online) i_key_online = 1'b1;
    else i_key_local = 1'b1;
    repeat (5) @(negedge i_sys_clk);
    i_key_online = 1'b0;
    i_key_local  = 1'b0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    chk("source after reset", 8'(hcpfe_pkg::HCPFE_SRC_SERIAL), 8'(o_src));
    chk("serial idle", 8'h01, 8'(o_ser_tx));
  endtask

  task automatic t_usb_switch;
    int d0;
    d0 = n_disp;
    run_cmd(1'b1, 8'h35, 1'b0, 8'h00, hcpfe_pkg::HCPFE_SRC_USB);
    chk("display pulses", 8'h01, 8'(n_disp - d0));
    run_cmd(1'b1, 8'h3c, 1'b0, 8'h00, hcpfe_pkg::HCPFE_SRC_USB);
    chk("display pulses", 8'h01, 8'(n_disp - d0));
  endtask

  task automatic t_param_stall;
    slow = 1'b1;
    run_cmd(1'b1, hcpfe_pkg::PARAM_CMD, 1'b1, 8'h42, hcpfe_pkg::HCPFE_SRC_USB);
    slow = 1'b0;
  endtask

  task automatic t_serial_switch;
    int d0;
    d0 = n_disp;
    run_cmd(1'b0, 8'h79, 1'b0, 8'h00, hcpfe_pkg::HCPFE_SRC_SERIAL);
    chk("display pulses", 8'h01, 8'(n_disp - d0));
  endtask

  task automatic t_keys;
    int c0;
    press(1'b0);
    chk("source local", 8'(hcpfe_pkg::HCPFE_SRC_LOCAL), 8'(o_src));
    c0 = n_cmd;
    send(1'b1, 8'h21);
    send(1'b0, 8'h22);
    repeat (250) @(negedge i_sys_clk);
    chk("commands in local", 8'h00, 8'(n_cmd - c0));
    chk("usb echoes", 8'h00, 8'(u_hcpfe_host_model.usb_q.size()));
    chk("serial echoes", 8'h00, 8'(u_hcpfe_host_model.ser_q.size()));
    press(1'b1);
    chk("source online", 8'(hcpfe_pkg::HCPFE_SRC_SERIAL), 8'(o_src));
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    i_rst        = 1'b1;
    i_key_online = 1'b0;
    i_key_local  = 1'b0;
    i_op_done    = 1'b0;
    slow         = 1'b0;
    repeat (6) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst = 1'b0;
    t_reset;
    t_usb_switch;
    t_param_stall;
    t_serial_switch;
    t_keys;
    end_sim;
  end

  // Whole run needs about a thousand cycles
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    num_errors++;
    end_sim;
  end
endmodule
